// ==== otplr_pkg.sv ====
package otplr_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int FETCH_US = 200;
	localparam int FETCH_CYC = FETCH_US * CLK_PER_US;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS * CLK_PER_US + 999) / 1000;
	localparam int HOLD_NS = 300;
	localparam int HOLD_CYC = (HOLD_NS * CLK_PER_US + 999) / 1000;
	localparam int HALF_NS = 400;
	localparam int HALF_CYC = (HALF_NS * CLK_PER_US + 999) / 1000;
	// ----------------------------------------
	// Serial frame and device register map
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int INST_BITS = 8;
	localparam int INST_RD = 7;
	localparam int NREG = 4;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam int CTRL_REFRESH = 0;
	localparam int CTRL_SRST = 1;
	localparam int CTRL_TEST = 2;
	localparam int CTRL_BUSY = 0;
	localparam logic [NREG*8-1:0] OTP_IMAGE = 32'h5A3C_1200;
	// ----------------------------------------
	// Host Avalon register map
	// ----------------------------------------
	localparam logic [1:0] AV_CMD = 2'h0;
	localparam logic [1:0] AV_STAT = 2'h1;
	localparam logic [1:0] AV_TXEN = 2'h2;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_READ = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_TXHOLD = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_RDATA_LSB = 8;
	typedef enum logic [1:0] {
		OTPLR_IDLE = 2'b00,
		OTPLR_CSLOW = 2'b01,
		OTPLR_SCLLO = 2'b11,
		OTPLR_SCLHI = 2'b10
	} otplr_hstate_t;
endpackage

// ==== otplr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface otplr_if;
	logic cs_n;
	logic sclk;
	logic tx_en;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	// Open-drain data line with pull-up
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport host(output cs_n, output sclk, output tx_en, output host_sda_o,
		output host_sda_oe, input sda);
	modport dev(input cs_n, input sclk, input tx_en, input sda, output dev_sda_o,
		output dev_sda_oe);
endinterface
`default_nettype wire

// ==== otplr_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module otplr_dev #(
	parameter int FETCH_CYCLES = otplr_pkg::FETCH_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	otplr_if.dev link,
	output logic [otplr_pkg::NREG*8-1:0] cfg_o,
	output logic fetch_busy_o,
	output logic factory_test_mode_o,
	output logic pa_enable_o
);
	localparam int FW = $clog2(FETCH_CYCLES + 1);
	localparam int SW = $clog2(otplr_pkg::SPIKE_CYC + 1);
	localparam int HW = $clog2(otplr_pkg::HOLD_CYC + 1);
	localparam int BW = $clog2(otplr_pkg::FRAME_BITS + 1);
	localparam logic [FW-1:0] FETCH_LAST = FW'(FETCH_CYCLES - 1);
	localparam logic [SW-1:0] SPIKE_LIM = SW'(otplr_pkg::SPIKE_CYC);
	localparam logic [HW-1:0] HOLD_LIM = HW'(otplr_pkg::HOLD_CYC);
	localparam logic [BW-1:0] BITS_INST = BW'(otplr_pkg::INST_BITS);
	localparam logic [BW-1:0] BITS_FRAME = BW'(otplr_pkg::FRAME_BITS);
	localparam logic [BW-1:0] BITS_LASTRD = BW'(otplr_pkg::FRAME_BITS - 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0][SW-1:0] flt_cnt;
		logic [1:0] flt;
		logic [HW-1:0] hold_cnt;
		logic sda_s;
		logic [BW-1:0] bitn;
		logic [otplr_pkg::FRAME_BITS-1:0] shreg;
		logic [otplr_pkg::INST_BITS-1:0] inst;
		logic [otplr_pkg::NREG-1:0][7:0] cfg;
		logic [FW-1:0] fetch_cnt;
		logic busy;
		logic test;
		logic sda_oe;
	} otplr_dst_t;

	otplr_dst_t s;
	otplr_dst_t next_s;
	logic [1:0] raw;
	logic scl_rise;
	logic scl_fall;
	logic [4:0] addr;
	logic [2:0] rd_idx;
	logic [7:0] rd_byte;
	logic [7:0] wr_val;
	logic frame_done;
	logic is_read;

	assign raw = {link.sda, link.sclk};

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// Spike filter on clock and data inputs
		for (int i = 0; i < 2; i++) begin
			if (raw[i] == s.flt[i]) begin
				next_s.flt_cnt[i] = '0;
			end else if (s.flt_cnt[i] == SPIKE_LIM) begin
				next_s.flt[i] = raw[i];
				next_s.flt_cnt[i] = '0;
			end else begin
				next_s.flt_cnt[i] = s.flt_cnt[i] + 1'b1;
			end
		end
		scl_rise = !s.flt[0] && next_s.flt[0];
		scl_fall = s.flt[0] && !next_s.flt[0];

		// Sensed data frozen for a while after the clock falls
		if (scl_fall) begin
			next_s.hold_cnt = HOLD_LIM;
		end else if (s.hold_cnt != '0) begin
			next_s.hold_cnt = s.hold_cnt - 1'b1;
		end else begin
			next_s.sda_s = s.flt[1];
		end

		// Fetch timer, loads the OTP image when done
		if (s.busy) begin
			if (s.fetch_cnt == FETCH_LAST) begin
				next_s.cfg = otplr_pkg::OTP_IMAGE;
				next_s.busy = 1'b0;
				next_s.fetch_cnt = '0;
			end else begin
				next_s.fetch_cnt = s.fetch_cnt + 1'b1;
			end
		end

		// Frame decode
		addr = s.inst[4:0];
		is_read = s.inst[otplr_pkg::INST_RD];
		rd_idx = 3'(BITS_LASTRD - s.bitn);
		if (addr == otplr_pkg::REG_CTRL) begin
			rd_byte = 8'h00;
			rd_byte[otplr_pkg::CTRL_BUSY] = s.busy;
			rd_byte[otplr_pkg::CTRL_TEST] = s.test;
		end else if (addr < 5'(otplr_pkg::NREG)) begin
			rd_byte = s.cfg[addr[1:0]];
		end else begin
			rd_byte = 8'h00;
		end
		wr_val = {s.shreg[6:0], s.sda_s};
		frame_done = 1'b0;

		if (link.cs_n) begin
			// Deselected module ignores the lines
			next_s.bitn = '0;
			next_s.sda_oe = 1'b0;
		end else begin
			if (scl_rise && s.bitn != BITS_FRAME) begin
				next_s.shreg = {s.shreg[otplr_pkg::FRAME_BITS-2:0], s.sda_s};
				next_s.bitn = s.bitn + 1'b1;
				if (s.bitn == BITS_INST - 1'b1) begin
					next_s.inst = wr_val;
				end
				frame_done = (s.bitn == BITS_LASTRD);
			end
			if (scl_fall) begin
				if (is_read && s.bitn >= BITS_INST && s.bitn < BITS_FRAME) begin
					next_s.sda_oe = !rd_byte[rd_idx];
				end else begin
					next_s.sda_oe = 1'b0;
				end
			end
		end

		// Register write at the end of a write frame
		if (frame_done && !is_read && !s.busy) begin
			if (addr == otplr_pkg::REG_CTRL) begin
				if (wr_val[otplr_pkg::CTRL_SRST]) begin
					next_s.test = 1'b0;
					next_s.cfg = otplr_pkg::OTP_IMAGE;
				end else if (wr_val[otplr_pkg::CTRL_REFRESH]) begin
					next_s.busy = 1'b1;
					next_s.fetch_cnt = '0;
				end else begin
					next_s.test = wr_val[otplr_pkg::CTRL_TEST];
				end
			end else if (addr < 5'(otplr_pkg::NREG)) begin
				next_s.cfg[addr[1:0]] = wr_val;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.flt <= 2'h3;
			s.sda_s <= 1'b1;
			s.busy <= 1'b1; // Power-on fetch starts at once
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = s.sda_oe;
	assign cfg_o = s.cfg;
	assign fetch_busy_o = s.busy;
	assign factory_test_mode_o = s.test;
	// Amplifier kept off while reloading or in test mode
	assign pa_enable_o = link.tx_en && !s.busy && !s.test;
endmodule
`default_nettype wire

// ==== otplr_host.sv ====
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module otplr_host #(
	parameter int STARTUP_CYCLES = otplr_pkg::FETCH_CYC,
	parameter int HALF_CYCLES = otplr_pkg::HALF_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	otplr_if.host link,
	input wire logic [1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	localparam int FW = $clog2(STARTUP_CYCLES + 1);
	localparam int DW = $clog2(HALF_CYCLES + 1);
	localparam logic [FW-1:0] START_LAST = FW'(STARTUP_CYCLES - 1);
	localparam logic [DW-1:0] HALF_LAST = DW'(HALF_CYCLES - 1);
	localparam logic [3:0] BIT_LAST = 4'(otplr_pkg::FRAME_BITS - 1);
	localparam logic [3:0] BIT_DATA = 4'(otplr_pkg::INST_BITS);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		otplr_pkg::otplr_hstate_t st;
		logic [DW-1:0] div;
		logic [3:0] bitn;
		logic [otplr_pkg::FRAME_BITS-1:0] shreg;
		logic [7:0] rsh;
		logic [7:0] rdata;
		logic rd;
		logic [FW-1:0] start_cnt;
		logic ready;
		logic [FW-1:0] reload_cnt;
		logic test;
		logic reload_pend;
		logic test_pend;
		logic test_new;
		logic txen_req;
		logic refused;
		logic ack;
		logic [31:0] rbus;
		logic cs_n;
		logic sclk;
		logic sda_oe;
	} otplr_hst_t;

	otplr_hst_t s;
	otplr_hst_t next_s;
	logic acc;
	logic cmd_wr;
	logic [4:0] c_addr;
	logic [7:0] c_data;
	logic c_rd;
	logic half_done;
	logic [31:0] stat;

	always_comb begin
		next_s = s;
		acc = (avs_read_i || avs_write_i) && !s.ack;
		next_s.ack = acc;
		c_addr = avs_writedata_i[otplr_pkg::CMD_ADDR_LSB +: 5];
		c_data = avs_writedata_i[7:0];
		c_rd = avs_writedata_i[otplr_pkg::CMD_READ];
		cmd_wr = avs_write_i && s.ack && avs_address_i == otplr_pkg::AV_CMD;
		half_done = (s.div == HALF_LAST);
		next_s.div = half_done ? '0 : s.div + 1'b1;

		// Power-on wait before the first serial access
		if (!s.ready) begin
			if (s.start_cnt == START_LAST) begin
				next_s.ready = 1'b1;
			end else begin
				next_s.start_cnt = s.start_cnt + 1'b1;
			end
		end
		if (s.reload_cnt != '0) begin
			next_s.reload_cnt = s.reload_cnt - 1'b1;
		end

		// Status word
		stat = 32'h0000_0000;
		stat[otplr_pkg::ST_BUSY] = (s.st != otplr_pkg::OTPLR_IDLE);
		stat[otplr_pkg::ST_READY] = s.ready;
		stat[otplr_pkg::ST_TXHOLD] = (s.reload_cnt != '0) || s.reload_pend || s.test
			|| s.test_pend || !s.ready;
		stat[otplr_pkg::ST_REFUSED] = s.refused;
		stat[otplr_pkg::ST_RDATA_LSB +: 8] = s.rdata;
		if (avs_read_i && acc) begin
			case (avs_address_i)
				otplr_pkg::AV_STAT: next_s.rbus = stat;
				otplr_pkg::AV_TXEN: next_s.rbus = {31'h0000_0000, s.txen_req};
				default: next_s.rbus = 32'h0000_0000;
			endcase
		end
		if (avs_write_i && s.ack && avs_address_i == otplr_pkg::AV_TXEN) begin
			next_s.txen_req = avs_writedata_i[0];
		end

		// Command acceptance
		if (cmd_wr) begin
			if (s.st != otplr_pkg::OTPLR_IDLE || !s.ready) begin
				next_s.refused = 1'b1;
			end else if (!c_rd && c_addr == otplr_pkg::REG_CTRL
				&& c_data[otplr_pkg::CTRL_REFRESH] && c_data[otplr_pkg::CTRL_SRST]) begin
				next_s.refused = 1'b1;
			end else begin
				next_s.refused = 1'b0;
				next_s.st = otplr_pkg::OTPLR_CSLOW;
				next_s.cs_n = 1'b0;
				next_s.div = '0;
				next_s.bitn = '0;
				next_s.rd = c_rd;
				next_s.shreg = {c_rd, 2'b00, c_addr, c_data};
				if (!c_rd && c_addr == otplr_pkg::REG_CTRL) begin
					// Mode changes take effect when the device applies them at frame end
					if (c_data[otplr_pkg::CTRL_SRST]) begin
						next_s.test_pend = 1'b1;
						next_s.test_new = 1'b0;
					end else if (c_data[otplr_pkg::CTRL_REFRESH]) begin
						next_s.reload_pend = 1'b1;
					end else begin
						next_s.test_pend = 1'b1;
						next_s.test_new = c_data[otplr_pkg::CTRL_TEST];
					end
				end
			end
		end

		// Serial engine, clock idles high
		case (s.st)
			otplr_pkg::OTPLR_IDLE: begin
				if (!cmd_wr) begin
					next_s.div = '0;
				end
			end
			otplr_pkg::OTPLR_CSLOW: begin
				if (half_done) begin
					next_s.st = otplr_pkg::OTPLR_SCLLO;
					next_s.sclk = 1'b0;
					next_s.sda_oe = !s.shreg[otplr_pkg::FRAME_BITS-1];
				end
			end
			otplr_pkg::OTPLR_SCLLO: begin
				if (half_done) begin
					next_s.st = otplr_pkg::OTPLR_SCLHI;
					next_s.sclk = 1'b1;
				end
			end
			otplr_pkg::OTPLR_SCLHI: begin
				if (half_done) begin
					next_s.rsh = {s.rsh[6:0], link.sda};
					next_s.shreg = {s.shreg[otplr_pkg::FRAME_BITS-2:0], 1'b0};
					next_s.bitn = s.bitn + 1'b1;
					if (s.bitn == BIT_LAST) begin
						next_s.st = otplr_pkg::OTPLR_IDLE;
						next_s.cs_n = 1'b1;
						next_s.sda_oe = 1'b0;
						// Reload hold counted from the end of the frame, like the device
						if (s.reload_pend) begin
							next_s.reload_cnt = START_LAST;
							next_s.reload_pend = 1'b0;
						end
						if (s.test_pend) begin
							next_s.test = s.test_new;
							next_s.test_pend = 1'b0;
						end
						if (s.rd) begin
							next_s.rdata = {s.rsh[6:0], link.sda};
						end
					end else begin
						next_s.st = otplr_pkg::OTPLR_SCLLO;
						next_s.sclk = 1'b0;
						if (s.rd && s.bitn + 1'b1 >= BIT_DATA) begin
							next_s.sda_oe = 1'b0;
						end else begin
							next_s.sda_oe = !s.shreg[otplr_pkg::FRAME_BITS-2];
						end
					end
				end
			end
			default: next_s.st = otplr_pkg::OTPLR_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.st <= otplr_pkg::OTPLR_IDLE;
			s.cs_n <= 1'b1;
			s.sclk <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s.ack;
	assign avs_readdata_o = s.rbus;
	assign link.cs_n = s.cs_n;
	assign link.sclk = s.sclk;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = s.sda_oe;
	// Transmit enable forced low in reload, test mode and start-up
	assign link.tx_en = s.txen_req && s.reload_cnt == '0 && !s.reload_pend && !s.test
		&& !s.test_pend && s.ready;
endmodule
`default_nettype wire

// ==== otplr_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module otplr_asserts #(
	parameter int FETCH_CYCLES = 50
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic tx_en,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic [otplr_pkg::NREG*8-1:0] cfg_o,
	input wire logic fetch_busy_o,
	input wire logic factory_test_mode_o,
	input wire logic pa_enable_o
);
	int busy_cnt;
	int up_cnt;
	// Fetch length and time since reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_cnt <= 0;
			up_cnt <= 0;
		end else begin
			busy_cnt <= fetch_busy_o ? busy_cnt + 1 : 0;
			up_cnt <= (up_cnt < FETCH_CYCLES) ? up_cnt + 1 : up_cnt;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_unsel;
		cs_n [*8];
	endsequence
	sequence s_low_half;
		!sclk [*8];
	endsequence
	property p_fetch_len;
		busy_cnt <= FETCH_CYCLES + 1;
	endproperty
	property p_fetch_img;
		$fell(fetch_busy_o) |-> cfg_o == otplr_pkg::OTP_IMAGE;
	endproperty
	property p_first_access;
		$fell(cs_n) |-> up_cnt >= FETCH_CYCLES;
	endproperty
	property p_test_exit;
		$fell(factory_test_mode_o) |-> cfg_o == otplr_pkg::OTP_IMAGE;
	endproperty
	property p_pa_gate;
		pa_enable_o |-> tx_en && !fetch_busy_o && !factory_test_mode_o;
	endproperty
	property p_unsel_quiet;
		s_unsel |-> !dev_sda_oe;
	endproperty
	property p_no_write_busy;
		fetch_busy_o && $past(fetch_busy_o) |-> $stable(cfg_o);
	endproperty
	property p_sclk_low;
		$fell(sclk) |-> s_low_half;
	endproperty
	property p_sda_hi_stable;
		!cs_n && sclk && $past(sclk) |-> $stable(host_sda_oe);
	endproperty
	a_fetch_len: assert property (p_fetch_len) else $error("fetch too long");
	a_fetch_img: assert property (p_fetch_img) else $error("no image after fetch");
	a_first_access: assert property (p_first_access) else $error("early access");
	a_test_exit: assert property (p_test_exit) else $error("bad test exit");
	a_pa_gate: assert property (p_pa_gate) else $error("pa enabled wrongly");
	a_unsel_quiet: assert property (p_unsel_quiet) else $error("drives unselected");
	a_no_write_busy: assert property (p_no_write_busy) else $error("cfg changed in fetch");
	a_sclk_low: assert property (p_sclk_low) else $error("sclk low too short");
	a_sda_hi_stable: assert property (p_sda_hi_stable) else $error("sda moved high");
endmodule
`default_nettype wire

// ==== otplr_load_and_reset_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module otplr_load_and_reset_control_tb;
	localparam int FETCH = 1500;
	localparam logic [31:0] IMG = otplr_pkg::OTP_IMAGE;
	typedef struct packed {logic [4:0] addr; logic [7:0] data;} otplr_row_t;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [1:0] av_addr = 2'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [31:0] cfg;
	logic [31:0] cfg2;
	logic busy;
	logic test;
	logic pa_en;
	int fail_count = 0;
	int num_checks = 0;
	otplr_row_t rows[3] = '{'{5'h01, 8'hA5}, '{5'h02, 8'h00}, '{5'h03, 8'hFF}};
	otplr_if link_if();
	otplr_if spare_if();
	// Spare module shares clock and data but is never selected
	assign spare_if.cs_n = 1'b1;
	assign spare_if.sclk = link_if.sclk;
	assign spare_if.tx_en = 1'b0;
	assign spare_if.host_sda_o = 1'b0;
	assign spare_if.host_sda_oe = link_if.host_sda_oe;
	otplr_host #(.STARTUP_CYCLES(FETCH)) otplr_host_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.link(link_if.host), .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
		.avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait));
	otplr_dev #(.FETCH_CYCLES(FETCH)) otplr_dev_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.link(link_if.dev), .cfg_o(cfg), .fetch_busy_o(busy), .factory_test_mode_o(test),
		.pa_enable_o(pa_en));
	otplr_dev #(.FETCH_CYCLES(FETCH)) otplr_dev_inst_b (.clk_i(clk_i), .resetn_i(resetn_i),
		.link(spare_if.dev), .cfg_o(cfg2), .fetch_busy_o(), .factory_test_mode_o(),
		.pa_enable_o());
	otplr_asserts #(.FETCH_CYCLES(FETCH)) otplr_asserts_inst (.clk_i(clk_i),
		.resetn_i(resetn_i), .cs_n(link_if.cs_n), .sclk(link_if.sclk), .tx_en(link_if.tx_en),
		.host_sda_oe(link_if.host_sda_oe), .dev_sda_oe(link_if.dev_sda_oe), .cfg_o(cfg),
		.fetch_busy_o(busy), .factory_test_mode_o(test), .pa_enable_o(pa_en));
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= wr;
		av_rd <= !wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (av_wait !== 1'b0 && n < 100);
		if (n >= 100) fail_count++;
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	// Start a frame and poll status until the link is idle
	task automatic frame(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		av(1'b1, otplr_pkg::AV_CMD, {15'h0, rd, 3'h0, a, d}, q);
		do begin
			av(1'b0, otplr_pkg::AV_STAT, 32'h0, q);
			n++;
		end while (q[otplr_pkg::ST_BUSY] !== 1'b0 && n < 1000);
	endtask
	// Main sequence
	initial begin
		logic [31:0] q;
		int n;
		repeat (3) @(posedge clk_i);
		chk({link_if.cs_n, link_if.sclk, busy, test}, 4'b1110);
		chk(cfg, 32'h0);
		resetn_i <= 1'b1;
		frame(1'b0, 5'h01, 8'h33, q);
		chk(q[otplr_pkg::ST_REFUSED], 1'b1);
		chk(busy, 1'b1);
		n = 0;
		do begin
			av(1'b0, otplr_pkg::AV_STAT, 32'h0, q);
			n++;
		end while (q[otplr_pkg::ST_READY] !== 1'b1 && n < 2000);
		chk({busy, cfg}, {1'b0, IMG});
		$display("test startup done");
		foreach (rows[i]) begin
			frame(1'b0, rows[i].addr, rows[i].data, q);
			chk(cfg[rows[i].addr*8 +: 8], rows[i].data);
			chk(cfg2, IMG);
			frame(1'b1, rows[i].addr, 8'h00, q);
			chk(q[15:8], rows[i].data);
		end
		$display("test rows done");
		av(1'b1, otplr_pkg::AV_TXEN, 32'h1, q);
		@(negedge clk_i);
		chk(pa_en, 1'b1);
		frame(1'b0, 5'h00, 8'h04, q);
		chk({test, link_if.tx_en, pa_en}, 3'b100);
		frame(1'b0, 5'h00, 8'h03, q);
		chk({q[otplr_pkg::ST_REFUSED], test}, 2'b11);
		frame(1'b0, 5'h00, 8'h02, q);
		chk({test, cfg}, {1'b0, IMG});
		$display("test modes done");
		frame(1'b0, 5'h00, 8'h01, q);
		chk({busy, link_if.tx_en, pa_en}, 3'b100);
		frame(1'b0, 5'h01, 8'h77, q);
		chk({busy, cfg[15:8]}, {1'b1, IMG[15:8]});
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
		chk(cfg, IMG);
		$display("test refresh done");
		@(posedge clk_i);
		resetn_i <= 1'b0;
		@(negedge clk_i);
		chk({busy, test, cfg}, {2'b10, 32'h0});
		@(posedge clk_i);
		resetn_i <= 1'b1;
		$display("test reset done");
		end_of_test();
	end
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk_i);
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
